/* File: sgm_modulator.sv */
// Data signal modulator top: APB registers, carrier mixing and sync
//
// Summary of operation
// - Output is modulator AND high carrier when high, low carrier when low.
// - Enable bit 7 set mixes inputs; cleared gives no output.
// - Enable clear holds pin low; selections kept; resumes when set again.
// - Control bit 5 reads the present modulated output.
// - Output invert bit 4 inverts output so it idles high.
// - Carrier invert bits flip the selected high or low carrier.
// - High sync bit 4 waits for high carrier fall before switching low.
// - Low sync bit 0 waits for low carrier fall before switching high.
// - With sync, the carrier pulse in progress finishes low before switching.
// - Without sync, narrowed pulses or spurs may appear in the output.
// - High carrier select codes pick pins, clocks, peripherals; 1111 reserved.
// - Low carrier select uses the same encoding; 1111 reserved.
// - Modulator source codes 00000-10000 valid; 10001-11111 reserved.
// - Block keeps modulating in sleep while its sources keep running; here clk must keep running too.
// - Any reset disables the block and restores register defaults.
// - Peripheral disable makes block inactive; re-enable gives reset values.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module sgm_modulator
   import sgm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Peripheral disable
   input wire logic modulator_power_off,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Carrier sources, index equals select code
   input wire logic [SGM_CAR_N-1:0] carrier_sources,
   // Modulator sources, code 1 slot unused (software bit)
   input wire logic [SGM_SRC_N-1:0] modulator_sources,
   // Output pin
   output logic modulated_output_pin
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   logic enable_q, output_invert_q, software_modulation_bit_q;
   logic high_carrier_invert_q, high_carrier_sync_en_q;
   logic low_carrier_invert_q, low_carrier_sync_en_q;
   logic [SGM_SRC_W-1:0] modulator_source_sel_q;
   logic [SGM_CAR_W-1:0] low_carrier_sel_q, high_carrier_sel_q;
   logic [31:0] prdata_d;
   logic blk_rst;
   // Peripheral disable acts as a held reset of everything
   assign blk_rst = sys_rst | modulator_power_off;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   localparam logic [31:0] A_CTRL = 32'(SGM_IDX_CTRL) * SGM_BYTES_PER_REG;
   localparam logic [31:0] A_CARRIER = 32'(SGM_IDX_CARRIER) * SGM_BYTES_PER_REG;
   localparam logic [31:0] A_SRC = 32'(SGM_IDX_SRC) * SGM_BYTES_PER_REG;
   localparam logic [31:0] A_LO_CAR = 32'(SGM_IDX_LO_CAR) * SGM_BYTES_PER_REG;
   localparam logic [31:0] A_HI_CAR = 32'(SGM_IDX_HI_CAR) * SGM_BYTES_PER_REG;
   wire access = psel & penable;
   wire wr_lane0 = access & pwrite & pstrb[0];
   wire hit_ctrl = paddr == A_CTRL;
   wire hit_carrier = paddr == A_CARRIER;
   wire hit_src = paddr == A_SRC;
   wire hit_lo_car = paddr == A_LO_CAR;
   wire hit_hi_car = paddr == A_HI_CAR;
   wire hit_any = hit_ctrl | hit_carrier | hit_src | hit_lo_car | hit_hi_car;
   wire [7:0] wb = pwdata[7:0];

   logic mixed_q;
   wire [7:0] rd_ctrl = {enable_q, 1'b0, mixed_q, output_invert_q, 3'b000,
                         software_modulation_bit_q};
   wire [7:0] rd_carrier = {2'b00, high_carrier_invert_q, high_carrier_sync_en_q,
                            2'b00, low_carrier_invert_q, low_carrier_sync_en_q};
   assign prdata_d = hit_ctrl ? {24'h000000, rd_ctrl} :
                     hit_carrier ? {24'h000000, rd_carrier} :
                     hit_src ? {27'h0000000, modulator_source_sel_q} :
                     hit_lo_car ? {28'h0000000, low_carrier_sel_q} :
                     hit_hi_car ? {28'h0000000, high_carrier_sel_q} : 32'h00000000;

   // Zero wait states; unmapped addresses answer with pslverr
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata <= (psel & ~penable & ~pwrite) ? prdata_d : 32'h00000000;
      end
   end

   // Writes land at the access edge where pready is high
   wire wr = wr_lane0 & pready;
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         enable_q <= SGM_RESET_VAL[SGM_EN_BIT];
         output_invert_q <= SGM_RESET_VAL[SGM_OUT_INV_BIT];
         software_modulation_bit_q <= SGM_RESET_VAL[SGM_SWBIT_BIT];
         high_carrier_invert_q <= SGM_RESET_VAL[SGM_HI_INV_BIT];
         high_carrier_sync_en_q <= SGM_RESET_VAL[SGM_HI_SYNC_BIT];
         low_carrier_invert_q <= SGM_RESET_VAL[SGM_LO_INV_BIT];
         low_carrier_sync_en_q <= SGM_RESET_VAL[SGM_LO_SYNC_BIT];
         modulator_source_sel_q <= SGM_RESET_VAL[SGM_SRC_W-1:0];
         low_carrier_sel_q <= SGM_RESET_VAL[SGM_CAR_W-1:0];
         high_carrier_sel_q <= SGM_RESET_VAL[SGM_CAR_W-1:0];
      end else if (wr) begin
         if (hit_ctrl) begin
            enable_q <= wb[SGM_EN_BIT];
            output_invert_q <= wb[SGM_OUT_INV_BIT];
            software_modulation_bit_q <= wb[SGM_SWBIT_BIT];
         end
         if (hit_carrier) begin
            high_carrier_invert_q <= wb[SGM_HI_INV_BIT];
            high_carrier_sync_en_q <= wb[SGM_HI_SYNC_BIT];
            low_carrier_invert_q <= wb[SGM_LO_INV_BIT];
            low_carrier_sync_en_q <= wb[SGM_LO_SYNC_BIT];
         end
         if (hit_src) begin
            modulator_source_sel_q <= wb[SGM_SRC_W-1:0];
         end
         if (hit_lo_car) begin
            low_carrier_sel_q <= wb[SGM_CAR_W-1:0];
         end
         if (hit_hi_car) begin
            high_carrier_sel_q <= wb[SGM_CAR_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Source selection
   // ****************************************************************
   logic high_raw_q, low_raw_q, mod_q;
   logic [SGM_SRC_N-1:0] mod_inputs;
   // Software bit takes code 1; a synchronous bit, so fast sources beat it
   assign mod_inputs = {modulator_sources[SGM_SRC_N-1:2], software_modulation_bit_q,
                        modulator_sources[0]};

   sgm_source_mux #(.SEL_W(SGM_CAR_W), .N(SGM_CAR_N)) u_high_mux (
      .clk(clk), .sys_rst(blk_rst), .sel(high_carrier_sel_q),
      .sources(carrier_sources), .picked_q(high_raw_q));
   sgm_source_mux #(.SEL_W(SGM_CAR_W), .N(SGM_CAR_N)) u_low_mux (
      .clk(clk), .sys_rst(blk_rst), .sel(low_carrier_sel_q),
      .sources(carrier_sources), .picked_q(low_raw_q));
   sgm_source_mux #(.SEL_W(SGM_SRC_W), .N(SGM_SRC_N)) u_mod_mux (
      .clk(clk), .sys_rst(blk_rst), .sel(modulator_source_sel_q),
      .sources(mod_inputs), .picked_q(mod_q));

   // Each select code routes its own input one cycle later; reserved codes stay low
   a_high_route: assert property (@(posedge clk) disable iff (blk_rst)
      32'(high_carrier_sel_q) < SGM_CAR_N
      |=> high_raw_q == $past(carrier_sources[high_carrier_sel_q]))
      else $error("high carrier routed wrong");
   a_low_route: assert property (@(posedge clk) disable iff (blk_rst)
      32'(low_carrier_sel_q) < SGM_CAR_N
      |=> low_raw_q == $past(carrier_sources[low_carrier_sel_q]))
      else $error("low carrier routed wrong");
   a_mod_route: assert property (@(posedge clk) disable iff (blk_rst)
      32'(modulator_source_sel_q) < SGM_SRC_N
      |=> mod_q == $past(mod_inputs[modulator_source_sel_q]))
      else $error("modulator routed wrong");
   a_low_reserved: assert property (@(posedge clk) disable iff (blk_rst)
      32'(low_carrier_sel_q) >= SGM_CAR_N
      |=> !low_raw_q)
      else $error("reserved low carrier code not low");
   a_mod_reserved: assert property (@(posedge clk) disable iff (blk_rst)
      32'(modulator_source_sel_q) >= SGM_SRC_N
      |=> !mod_q)
      else $error("reserved modulator code not low");
   a_swbit_route: assert property (@(posedge clk) disable iff (blk_rst)
      modulator_source_sel_q == SGM_SRC_SWBIT
      |=> mod_q == $past(software_modulation_bit_q))
      else $error("software bit not routed");

   wire high_car = high_raw_q ^ high_carrier_invert_q;
   wire low_car = low_raw_q ^ low_carrier_invert_q;

   // ****************************************************************
   // Carrier switch with optional falling-edge synchronisation
   // ****************************************************************
   // use_high_q tracks which carrier is being mixed; it follows the
   // modulator at once unless sync holds it until the active carrier is low.
   logic use_high_q, use_high_d;
   wire want_switch = mod_q != use_high_q;
   wire hold_high = use_high_q & high_carrier_sync_en_q & high_car;
   wire hold_low = ~use_high_q & low_carrier_sync_en_q & low_car;
   // Unsynced switching may chop a pulse; that is accepted
   assign use_high_d = (want_switch & ~hold_high & ~hold_low) ? mod_q : use_high_q;
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         use_high_q <= 1'b0;
      end else begin
         use_high_q <= use_high_d;
      end
   end

   // Once the running carrier is low, a pending switch is taken at the next edge
   a_hi_release: assert property (@(posedge clk) disable iff (blk_rst)
      use_high_q && !mod_q && !(high_carrier_sync_en_q && high_car)
      |=> !use_high_q)
      else $error("high carrier held too long");
   a_lo_release: assert property (@(posedge clk) disable iff (blk_rst)
      !use_high_q && mod_q && !(low_carrier_sync_en_q && low_car)
      |=> use_high_q)
      else $error("low carrier held too long");

   // Carrier alone carries the output; the modulator picks which one.
   // Plain AND with modulator would kill the low carrier, so FSK needs this.
   wire active_car = use_high_d ? high_car : low_car;
   wire mixed_d = enable_q & active_car;
   wire pin_d = enable_q & (mixed_d ^ output_invert_q);
   // Fully clocked by clk, so it keeps running in sleep while clk does
   always_ff @(posedge clk) begin
      if (blk_rst) begin
         mixed_q <= 1'b0;
         modulated_output_pin <= 1'b0;
      end else begin
         mixed_q <= mixed_d;
         modulated_output_pin <= pin_d;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_apb_setup;
      psel & ~penable;
   endsequence
   // Setup followed by the access edge at which the slave answers
   sequence s_apb_xfer;
      s_apb_setup ##1 (psel & penable & pready);
   endsequence

   // Output path
   a_disabled_pin_low: assert property (@(posedge clk) disable iff (blk_rst)
      !enable_q |=> !modulated_output_pin) else $error("pin not low when disabled");
   a_out_status_match: assert property (@(posedge clk) disable iff (blk_rst)
      enable_q && $stable(enable_q)
      |-> modulated_output_pin == (mixed_q ^ $past(output_invert_q)))
      else $error("status bit disagrees with pin");
   a_invert_idle: assert property (@(posedge clk) disable iff (blk_rst)
      enable_q && !active_car |=> modulated_output_pin == $past(output_invert_q))
      else $error("idle level wrong");
   a_high_sync_hold: assert property (@(posedge clk) disable iff (blk_rst)
      use_high_q && high_carrier_sync_en_q && high_car |=> use_high_q)
      else $error("switched during high carrier pulse");
   a_low_sync_hold: assert property (@(posedge clk) disable iff (blk_rst)
      !use_high_q && low_carrier_sync_en_q && low_car |=> !use_high_q)
      else $error("switched during low carrier pulse");
   a_nosync_follow: assert property (@(posedge clk) disable iff (blk_rst)
      !high_carrier_sync_en_q && !low_carrier_sync_en_q |=> use_high_q == $past(mod_q))
      else $error("unsynced switch late");
   a_mix_carrier: assert property (@(posedge clk) disable iff (blk_rst)
      enable_q |=> mixed_q == $past(use_high_d ? high_car : low_car))
      else $error("wrong carrier mixed");
   a_enable_gate: assert property (@(posedge clk) disable iff (blk_rst)
      !enable_q |=> !mixed_q) else $error("mixed while disabled");
   a_reserved_low: assert property (@(posedge clk) disable iff (blk_rst)
      high_carrier_sel_q == 4'hf && $stable(high_carrier_sel_q) |=> !high_raw_q)
      else $error("reserved code not low");
   a_sel_kept: assert property (@(posedge clk) disable iff (blk_rst)
      !enable_q && !wr
      |=> $stable(high_carrier_sel_q) && $stable(low_carrier_sel_q))
      else $error("selection lost while disabled");

   // Register bus
   a_apb_answer: assert property (@(posedge clk) disable iff (blk_rst)
      s_apb_setup |=> pready) else $error("no pready after setup");
   a_apb_pulse: assert property (@(posedge clk) disable iff (blk_rst)
      s_apb_xfer |=> !pready)
      else $error("pready held past access");
   a_slverr_map: assert property (@(posedge clk) disable iff (blk_rst)
      psel && !penable
      |=> pslverr == $past(!hit_any))
      else $error("error response wrong");
   a_rd_idle_zero: assert property (@(posedge clk) disable iff (blk_rst)
      !pready |-> prdata == 32'h00000000)
      else $error("read data outside answer");
   a_status_read: assert property (@(posedge clk) disable iff (blk_rst)
      psel && !penable && !pwrite && hit_ctrl
      |=> prdata[SGM_OUT_BIT] == $past(mixed_q))
      else $error("status bit read wrong");
   a_write_ctrl: assert property (@(posedge clk) disable iff (blk_rst)
      wr && hit_ctrl
      |=> enable_q == $past(wb[SGM_EN_BIT]) && output_invert_q == $past(wb[SGM_OUT_INV_BIT]))
      else $error("control write lost");
   a_hi_sel_write: assert property (@(posedge clk) disable iff (blk_rst)
      wr && hit_hi_car
      |=> high_carrier_sel_q == $past(wb[SGM_CAR_W-1:0]))
      else $error("high carrier select write lost");
   a_bad_write: assert property (@(posedge clk) disable iff (blk_rst)
      access && pwrite && pready && !hit_any
      |=> $stable(enable_q) && $stable(modulator_source_sel_q))
      else $error("unmapped write changed a register");

   // Reset and peripheral disable
   a_block_reset: assert property (@(posedge clk)
      blk_rst |=> !enable_q && !modulated_output_pin && modulator_source_sel_q == 5'h00)
      else $error("reset not applied");
   a_power_off_quiet: assert property (@(posedge clk)
      modulator_power_off
      |=> !pready && !pslverr && prdata == 32'h00000000)
      else $error("bus active while powered off");
endmodule // sgm_modulator

/* File: sgm_pkg.sv */
// Package for the signal modulator: register map, fields, select codes
package sgm_pkg;
   // ****************************************************************
   // Register indices (printed offsets are not multiples of four)
   // ****************************************************************
   localparam logic [11:0] SGM_IDX_CTRL = 12'h897;
   localparam logic [11:0] SGM_IDX_CARRIER = 12'h898;
   localparam logic [11:0] SGM_IDX_SRC = 12'h899;
   localparam logic [11:0] SGM_IDX_LO_CAR = 12'h89a;
   localparam logic [11:0] SGM_IDX_HI_CAR = 12'h89b;
   localparam int SGM_BYTES_PER_REG = 4;
   localparam logic [7:0] SGM_RESET_VAL = 8'h00;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SGM_EN_BIT = 7;
   localparam int SGM_OUT_BIT = 5;
   localparam int SGM_OUT_INV_BIT = 4;
   localparam int SGM_SWBIT_BIT = 0;
   localparam int SGM_HI_INV_BIT = 5;
   localparam int SGM_HI_SYNC_BIT = 4;
   localparam int SGM_LO_INV_BIT = 1;
   localparam int SGM_LO_SYNC_BIT = 0;
   localparam int SGM_CAR_W = 4;
   localparam int SGM_SRC_W = 5;
   localparam int SGM_CAR_N = 15;
   localparam int SGM_SRC_N = 17;
   localparam logic [4:0] SGM_SRC_SWBIT = 5'h01;
endpackage

/* File: sgm_source_mux.sv */
// Source selector: picks one input by code, reserved codes give low
`timescale 1ns/10ps
module sgm_source_mux #(
   parameter int SEL_W = 4,
   parameter int N = 15
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Selection
   input wire logic [SEL_W-1:0] sel,
   input wire logic [N-1:0] sources,
   // Registered selected source
   output logic picked_q
);
   logic picked_d;
   // Reserved codes read as constant low
   assign picked_d = (32'(sel) < N) ? sources[sel] : 1'b0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         picked_q <= 1'b0;
      end else begin
         picked_q <= picked_d;
      end
   end
endmodule // sgm_source_mux

/* File: sgm_src_model.sv */
// Far-side model: peripheral outputs and pins feeding carriers and modulator
`timescale 1ns/10ps
module sgm_src_model (
   // Clock
   input wire logic clk,
   // Levels requested by the bench
   input wire logic [14:0] car_req,
   input wire logic [16:0] mod_req,
   // Source lines into the block
   output logic [14:0] carrier_sources,
   output logic [16:0] modulator_sources
);
   // Sources change only just after an edge, like any on-chip peripheral output
   initial begin
      carrier_sources = 15'h0000;
      modulator_sources = 17'h00000;
   end
   always @(posedge clk) begin
      carrier_sources <= car_req;
      modulator_sources <= mod_req;
   end
endmodule // sgm_src_model

/* File: tb_data_signal_modulator.sv */
// Self-checking bench for the signal modulator
`timescale 1ns/10ps
module tb_data_signal_modulator;
   import sgm_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, modulator_power_off = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pin;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'h0;
   logic [14:0] car = 15'h0, cs;
   logic [16:0] mod = 17'h0, ms;
   int err_count = 0, checks = 0;
   sgm_src_model src_u (.clk(clk), .car_req(car), .mod_req(mod), .carrier_sources(cs),
      .modulator_sources(ms));
   sgm_modulator dut_u (.clk(clk), .sys_rst(sys_rst), .modulator_power_off(modulator_power_off),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .carrier_sources(cs), .modulator_sources(ms), .modulated_output_pin(pin));
   initial begin
      forever #10 clk = ~clk;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Setup starts one edge after any release, so no signal is driven twice in a step
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; pstrb <= 4'hf;
      paddr <= {18'h0, idx, 2'b00}; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         final_report();
      end
   endtask
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 32'h0, r, e);
      check(r, x);
      check({31'h0, e}, 32'h0);
   endtask
   // Two cycles of datapath plus one in the source model; five leaves margin
   task automatic pinchk(input logic [14:0] c, input logic [16:0] m, input logic x);
      car <= c; mod <= m;
      repeat (5) @(posedge clk);
      check({31'h0, pin}, {31'h0, x});
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      logic [7:0] m[4] = '{8'h33, 8'h1f, 8'h0f, 8'h0f};
      for (int i = 0; i < 5; i++) rd(SGM_IDX_CTRL + 12'(i), 32'h0);
      apb(1'b0, 12'h8a0, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      wr(12'h8a0, 32'hffffffff);
      rd(SGM_IDX_CTRL, 32'h0);
      wr(SGM_IDX_CTRL, 32'h6e);
      rd(SGM_IDX_CTRL, 32'h0);
      for (int i = 1; i < 5; i++) begin
         wr(SGM_IDX_CTRL + 12'(i), 32'hffffffff);
         rd(SGM_IDX_CTRL + 12'(i), {24'h0, m[i-1]});
         wr(SGM_IDX_CTRL + 12'(i), 32'h0);
      end
      $display("test regs done");
   endtask
   task automatic t_carriers;
      logic [14:0] oh;
      wr(SGM_IDX_SRC, {27'h0, SGM_SRC_SWBIT});
      for (int h = 0; h < 2; h++) begin
         // Software bit only with static sources, so its value is always valid
         wr(SGM_IDX_CTRL, h ? 32'h81 : 32'h80);
         for (int c = 0; c < 16; c++) begin
            oh = (c < 15) ? 15'(1 << c) : 15'h7fff;
            wr(h ? SGM_IDX_HI_CAR : SGM_IDX_LO_CAR, 32'(c));
            pinchk(oh, 17'h0, c < 15);
            if (c < 15) pinchk(~oh, 17'h0, 1'b0);
         end
      end
      $display("test carriers done");
   endtask
   task automatic t_sources;
      logic [16:0] oh;
      wr(SGM_IDX_HI_CAR, 32'h1);
      wr(SGM_IDX_LO_CAR, 32'hf);
      for (int s = 0; s < 32; s++) begin
         if (s != 1) begin
            oh = (s < 17) ? 17'(1 << s) : 17'h1ffff;
            wr(SGM_IDX_SRC, 32'(s));
            pinchk(15'h7fff, oh, s < 17);
            if (s < 17) pinchk(15'h7fff, ~oh, 1'b0);
         end
      end
      $display("test sources done");
   endtask
   task automatic t_polarity;
      wr(SGM_IDX_SRC, {27'h0, SGM_SRC_SWBIT});
      wr(SGM_IDX_LO_CAR, 32'h2);
      wr(SGM_IDX_CTRL, 32'h81);
      pinchk(15'h0002, 17'h0, 1'b1);
      wr(SGM_IDX_CARRIER, 32'h20);
      pinchk(15'h0002, 17'h0, 1'b0);
      rd(SGM_IDX_CTRL, 32'h81);
      wr(SGM_IDX_CARRIER, 32'h0);
      wr(SGM_IDX_CTRL, 32'h91);
      pinchk(15'h0002, 17'h0, 1'b0);
      rd(SGM_IDX_CTRL, 32'hb1);
      wr(SGM_IDX_CTRL, 32'h90);
      pinchk(15'h0002, 17'h0, 1'b1);
      wr(SGM_IDX_CARRIER, 32'h02);
      pinchk(15'h0002, 17'h0, 1'b0);
      wr(SGM_IDX_CARRIER, 32'h0);
      $display("test polarity done");
   endtask
   task automatic t_enable;
      wr(SGM_IDX_CTRL, 32'h01);
      pinchk(15'h0002, 17'h0, 1'b0);
      rd(SGM_IDX_HI_CAR, 32'h1);
      wr(SGM_IDX_CTRL, 32'h11);
      pinchk(15'h0002, 17'h0, 1'b0);
      wr(SGM_IDX_CTRL, 32'h81);
      pinchk(15'h0002, 17'h0, 1'b1);
      modulator_power_off <= 1'b1;
      pinchk(15'h0002, 17'h0, 1'b0);
      modulator_power_off <= 1'b0;
      rd(SGM_IDX_CTRL, 32'h0);
      rd(SGM_IDX_HI_CAR, 32'h0);
      $display("test enable done");
   endtask
   task automatic t_sync;
      wr(SGM_IDX_SRC, {27'h0, SGM_SRC_SWBIT});
      wr(SGM_IDX_HI_CAR, 32'h1);
      wr(SGM_IDX_LO_CAR, 32'h2);
      for (int y = 0; y < 2; y++) begin
         wr(SGM_IDX_CARRIER, y ? 32'h10 : 32'h0);
         wr(SGM_IDX_CTRL, 32'h81);
         pinchk(15'h0002, 17'h0, 1'b1);
         wr(SGM_IDX_CTRL, 32'h80);
         pinchk(15'h0002, 17'h0, y == 1);
         pinchk(15'h0000, 17'h0, 1'b0);
      end
      wr(SGM_IDX_CARRIER, 32'h01);
      pinchk(15'h0004, 17'h0, 1'b1);
      wr(SGM_IDX_CTRL, 32'h81);
      pinchk(15'h0004, 17'h0, 1'b1);
      pinchk(15'h0000, 17'h0, 1'b0);
      $display("test sync done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_carriers();
      t_sources();
      t_polarity();
      t_enable();
      t_sync();
      final_report();
   end
endmodule // tb_data_signal_modulator
